// >>> wdsm_map.vh
// Purpose: Register indices, field positions and reset values of the watchdog/monitor block
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef WDSM_MAP_VH
`define WDSM_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices
`define WDSM_IDX_TEST0      10'h03d
`define WDSM_IDX_TEST1      10'h03e
`define WDSM_IDX_SERVICE    10'h03f
`define WDSM_IDX_TEMP       10'h2f0
`define WDSM_IDX_LVOLT      10'h2f1
`define WDSM_IDX_WD_STAT    10'h2f8
`define WDSM_IDX_WD_MASK    10'h2f9
`define WDSM_IDX_WD_STATE   10'h2fa

////////////////////////////////////////////////////////////////////////////////
// Service codes and watchdog-off rate select code
`define WDSM_SVC_ARM        8'h55
`define WDSM_SVC_FIRE       8'haa
`define WDSM_SVC_READ       8'h00
`define WDSM_RATE_OFF       3'h0

////////////////////////////////////////////////////////////////////////////////
// Field positions in the monitor registers
`define WDSM_B_FLAG         0
`define WDSM_B_IE           1
`define WDSM_B_STAT         2
`define WDSM_B_TEN          3
`define WDSM_B_MONITOR_VOLTAGE_SELECT         5

////////////////////////////////////////////////////////////////////////////////
// Watchdog event bits, state bits
`define WDSM_EV_VALUE       0
`define WDSM_EV_WINDOW      1
`define WDSM_EV_TIMEOUT     2
`define WDSM_ST_ARMED       0
`define WDSM_ST_WINDOW      1
`define WDSM_ST_ENABLED     2

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define WDSM_TEST_RST       8'h00
`define WDSM_BIT_RST        1'b0
`define WDSM_EV_RST         3'h0
`define WDSM_RDATA_ZERO     32'h0000_0000

`endif

// >>> wdsm_wdog.v
// Purpose: Watchdog counter, service sequence and reset requests
// Assumes: tick is a one-cycle pulse per watchdog clock cycle, synchronous to pclk
// Notes:   Reset requests are one-cycle pulses from flip-flops
`include "wdsm_map.vh"
`default_nettype none

module wdsm_wdog #(
    parameter       CNT_W = 24,
    parameter [4:0] EXP_1 = 5'd14,
    parameter [4:0] EXP_2 = 5'd16,
    parameter [4:0] EXP_3 = 5'd18,
    parameter [4:0] EXP_4 = 5'd20,
    parameter [4:0] EXP_5 = 5'd22,
    parameter [4:0] EXP_6 = 5'd23,
    parameter [4:0] EXP_7 = 5'd24
) (
    input  wire       pclk,
    input  wire       presetn,
    input  wire [2:0] rate_select,
    input  wire       window_mode,
    input  wire       tick,
    input  wire       svc_wr,
    input  wire [7:0] svc_data,
    output reg        value_rst_req,
    output reg        window_rst_req,
    output reg        timeout_rst_req,
    output wire       armed,
    output wire       window_open
);

    // Last count of the selected period
    function [CNT_W-1:0] wd_limit;
        input [2:0] code;
        reg   [4:0] e;
        begin
            case (code)
                3'd1:    e = EXP_1;
                3'd2:    e = EXP_2;
                3'd3:    e = EXP_3;
                3'd4:    e = EXP_4;
                3'd5:    e = EXP_5;
                3'd6:    e = EXP_6;
                default: e = EXP_7;
            endcase
            wd_limit = {CNT_W{1'b1}} >> (CNT_W - e);
        end
    endfunction

    reg  [CNT_W-1:0] cnt_reg;
    reg              armed_reg;
    wire             enabled   = (rate_select != `WDSM_RATE_OFF);
    wire [CNT_W-1:0] limit     = wd_limit(rate_select);
    wire [CNT_W-1:0] win_start = limit - (limit >> 2);

    assign armed       = armed_reg;
    assign window_open = enabled & (~window_mode | (cnt_reg >= win_start));

    ////////////////////////////////////////////////////////////////////////////
    // Counter and sequence
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg         <= {CNT_W{1'b0}};
            armed_reg       <= `WDSM_BIT_RST;
            value_rst_req   <= `WDSM_BIT_RST;
            window_rst_req  <= `WDSM_BIT_RST;
            timeout_rst_req <= `WDSM_BIT_RST;
        end else begin
            value_rst_req   <= 1'b0;
            window_rst_req  <= 1'b0;
            timeout_rst_req <= 1'b0;
            if (!enabled) begin
                cnt_reg   <= {CNT_W{1'b0}};
                armed_reg <= 1'b0;
            end else if (svc_wr) begin
                if (window_mode && cnt_reg < win_start) begin
                    window_rst_req <= 1'b1;
                    cnt_reg        <= {CNT_W{1'b0}};
                    armed_reg      <= 1'b0;
                end else if (svc_data == `WDSM_SVC_ARM) begin
                    armed_reg <= 1'b1;
                end else if (svc_data == `WDSM_SVC_FIRE) begin
                    if (armed_reg) begin
                        cnt_reg   <= {CNT_W{1'b0}};
                        armed_reg <= 1'b0;
                    end
                end else begin
                    value_rst_req <= 1'b1;
                    cnt_reg       <= {CNT_W{1'b0}};
                    armed_reg     <= 1'b0;
                end
            end else if (tick) begin
                if (cnt_reg == limit) begin
                    timeout_rst_req <= 1'b1;
                    cnt_reg         <= {CNT_W{1'b0}};
                    armed_reg       <= 1'b0;
                end else begin
                    cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // wdsm_wdog

`default_nettype wire

// >>> wdsm_top.v
// Purpose: Watchdog service register, temperature and low-voltage monitor registers
// Assumes: APB3 slave, 32-bit data, byte address is four times the register index
// Notes:   Every access has one access cycle; unmapped addresses answer pslverr
//
// Function
// - Rate select zero: service writes ignored, no restart, no reset.
// - Enabled watchdog: service value other than 55/AA raises watchdog reset.
// - 55 then later AA restarts timeout; missing the period causes reset.
// - Window mode: any service write in first 75% raises watchdog reset.
// - Service register always reads zero.
// - Factory test registers readable always, writable only in special mode.
// - Voltage select bit 5: one routes bandgap, zero routes temperature voltage.
// - Temperature sense enable at bit 3 switches sensor on.
// - Temperature detect status bit 2 is read-only, high above level in full power.
// - Temperature change flag bit 0 sets on status change, write one clears.
// - Temperature interrupt while change flag and enable bit 1 both set.
// - Low-voltage status bit 2 is read-only, high when supply low in full power.
// - Low-voltage change flag bit 0 sets on status change, write one clears.
// - Low-voltage interrupt while change flag and enable bit 1 both set.
// - Nonzero rate select enables watchdog with periods 2^14 up to 2^24.
// - Window mode input; completed sequence restarts period and window.
//
// The APB slave port was left to the implementer.
`include "wdsm_map.vh"
`default_nettype none

module wdsm_top #(
    parameter       CNT_W = 24,
    parameter [4:0] EXP_1 = 5'd14,
    parameter [4:0] EXP_2 = 5'd16,
    parameter [4:0] EXP_3 = 5'd18,
    parameter [4:0] EXP_4 = 5'd20,
    parameter [4:0] EXP_5 = 5'd22,
    parameter [4:0] EXP_6 = 5'd23,
    parameter [4:0] EXP_7 = 5'd24
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        special_mode,
    input  wire        wd_tick,
    input  wire [2:0]  wd_rate_select,
    input  wire        window_service_mode,
    input  wire        temp_above_in,
    input  wire        supply_low_in,
    input  wire        full_power_state,
    output wire        temp_sense_enable,
    output wire        monitor_voltage_select,
    output reg         temp_irq,
    output reg         low_voltage_irq,
    output wire        wd_value_rst_req,
    output wire        wd_window_rst_req,
    output wire        wd_timeout_rst_req,
    output reg         irq
);

    // Word hit on an aligned address
    function reg_hit;
        input [11:0] a;
        input [9:0]  idx;
        begin
            reg_hit = (a[1:0] == 2'b00) && (a[11:2] == idx);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus phases
    wire       setup_ph  = psel & ~penable;
    wire       access_ph = psel & penable & pready;
    wire       wr_en     = access_ph & pwrite;
    wire [7:0] wbyte     = pwdata[7:0];

    wire hit_test0   = reg_hit(paddr, `WDSM_IDX_TEST0);
    wire hit_test1   = reg_hit(paddr, `WDSM_IDX_TEST1);
    wire hit_service = reg_hit(paddr, `WDSM_IDX_SERVICE);
    wire hit_temp    = reg_hit(paddr, `WDSM_IDX_TEMP);
    wire hit_lvolt   = reg_hit(paddr, `WDSM_IDX_LVOLT);
    wire hit_wd_stat = reg_hit(paddr, `WDSM_IDX_WD_STAT);
    wire hit_wd_mask = reg_hit(paddr, `WDSM_IDX_WD_MASK);
    wire hit_wd_st   = reg_hit(paddr, `WDSM_IDX_WD_STATE);
    wire mapped      = hit_test0 | hit_test1 | hit_service | hit_temp | hit_lvolt |
                       hit_wd_stat | hit_wd_mask | hit_wd_st;

    wire wr_test     = wr_en & special_mode;
    wire wr_service  = wr_en & hit_service;
    wire wr_temp     = wr_en & hit_temp;
    wire wr_lvolt    = wr_en & hit_lvolt;
    wire wr_wd_stat  = wr_en & hit_wd_stat;
    wire wr_wd_mask  = wr_en & hit_wd_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    reg  [7:0] test0_reg;
    reg  [7:0] test1_reg;
    reg        monitor_voltage_select_reg;
    reg        ten_reg;
    reg        temp_stat_reg;
    reg        temp_ie_reg;
    reg        temp_flag_reg;
    reg        lv_stat_reg;
    reg        lv_ie_reg;
    reg        lv_flag_reg;
    reg  [2:0] wd_ev_reg;
    reg  [2:0] wd_mask_reg;
    reg        temp_flag_next;
    reg        lv_flag_next;
    reg        temp_ie_next;
    reg        lv_ie_next;
    reg  [2:0] wd_ev_next;
    reg  [2:0] wd_mask_next;
    reg  [7:0] rbyte_next;
    wire       wd_armed;
    wire       wd_window_open;
    wire       temp_stat_next = temp_above_in & full_power_state;
    wire       lv_stat_next   = supply_low_in & full_power_state;
    wire [2:0] wd_events      = {wd_timeout_rst_req, wd_window_rst_req, wd_value_rst_req};

    assign temp_sense_enable      = ten_reg;
    assign monitor_voltage_select = monitor_voltage_select_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog core
    wdsm_wdog #(
        .CNT_W (CNT_W),
        .EXP_1 (EXP_1),
        .EXP_2 (EXP_2),
        .EXP_3 (EXP_3),
        .EXP_4 (EXP_4),
        .EXP_5 (EXP_5),
        .EXP_6 (EXP_6),
        .EXP_7 (EXP_7)
    ) u_wdog (
        .pclk            (pclk),
        .presetn         (presetn),
        .rate_select     (wd_rate_select),
        .window_mode     (window_service_mode),
        .tick            (wd_tick),
        .svc_wr          (wr_service),
        .svc_data        (wbyte),
        .value_rst_req   (wd_value_rst_req),
        .window_rst_req  (wd_window_rst_req),
        .timeout_rst_req (wd_timeout_rst_req),
        .armed           (wd_armed),
        .window_open     (wd_window_open)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next values of flags and enables
    always @* begin
        temp_ie_next   = wr_temp  ? wbyte[`WDSM_B_IE] : temp_ie_reg;
        lv_ie_next     = wr_lvolt ? wbyte[`WDSM_B_IE] : lv_ie_reg;
        temp_flag_next = (temp_flag_reg & ~(wr_temp & wbyte[`WDSM_B_FLAG])) |
                         (temp_stat_next ^ temp_stat_reg);
        lv_flag_next   = (lv_flag_reg & ~(wr_lvolt & wbyte[`WDSM_B_FLAG])) |
                         (lv_stat_next ^ lv_stat_reg);
        wd_ev_next     = (wd_ev_reg & ~({3{wr_wd_stat}} & wbyte[2:0])) | wd_events;
        wd_mask_next   = wr_wd_mask ? wbyte[2:0] : wd_mask_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer, decoded in the setup phase
    always @* begin
        rbyte_next = 8'h00;
        case (1'b1)
            hit_test0: begin
                rbyte_next = test0_reg;
            end
            hit_test1: begin
                rbyte_next = test1_reg;
            end
            hit_service: begin
                rbyte_next = `WDSM_SVC_READ;
            end
            hit_temp: begin
                rbyte_next[`WDSM_B_MONITOR_VOLTAGE_SELECT] = monitor_voltage_select_reg;
                rbyte_next[`WDSM_B_TEN]  = ten_reg;
                rbyte_next[`WDSM_B_STAT] = temp_stat_reg;
                rbyte_next[`WDSM_B_IE]   = temp_ie_reg;
                rbyte_next[`WDSM_B_FLAG] = temp_flag_reg;
            end
            hit_lvolt: begin
                rbyte_next[`WDSM_B_STAT] = lv_stat_reg;
                rbyte_next[`WDSM_B_IE]   = lv_ie_reg;
                rbyte_next[`WDSM_B_FLAG] = lv_flag_reg;
            end
            hit_wd_stat: begin
                rbyte_next[2:0] = wd_ev_reg;
            end
            hit_wd_mask: begin
                rbyte_next[2:0] = wd_mask_reg;
            end
            hit_wd_st: begin
                rbyte_next[`WDSM_ST_ARMED]   = wd_armed;
                rbyte_next[`WDSM_ST_WINDOW]  = wd_window_open;
                rbyte_next[`WDSM_ST_ENABLED] = (wd_rate_select != `WDSM_RATE_OFF);
            end
            default: begin
                rbyte_next = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= `WDSM_BIT_RST;
            pslverr <= `WDSM_BIT_RST;
            prdata  <= `WDSM_RDATA_ZERO;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~mapped;
            if (setup_ph) begin
                prdata <= {24'h00_0000, rbyte_next};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Factory test registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test0_reg <= `WDSM_TEST_RST;
            test1_reg <= `WDSM_TEST_RST;
        end else begin
            if (wr_test & hit_test0) begin
                test0_reg <= wbyte;
            end
            if (wr_test & hit_test1) begin
                test1_reg <= wbyte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Temperature monitor
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            monitor_voltage_select_reg      <= `WDSM_BIT_RST;
            ten_reg       <= `WDSM_BIT_RST;
            temp_stat_reg <= `WDSM_BIT_RST;
            temp_ie_reg   <= `WDSM_BIT_RST;
            temp_flag_reg <= `WDSM_BIT_RST;
            temp_irq      <= `WDSM_BIT_RST;
        end else begin
            if (wr_temp) begin
                monitor_voltage_select_reg <= wbyte[`WDSM_B_MONITOR_VOLTAGE_SELECT];
                ten_reg  <= wbyte[`WDSM_B_TEN];
            end
            temp_stat_reg <= temp_stat_next;
            temp_ie_reg   <= temp_ie_next;
            temp_flag_reg <= temp_flag_next;
            temp_irq      <= temp_flag_next & temp_ie_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low-voltage monitor
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_stat_reg     <= `WDSM_BIT_RST;
            lv_ie_reg       <= `WDSM_BIT_RST;
            lv_flag_reg     <= `WDSM_BIT_RST;
            low_voltage_irq <= `WDSM_BIT_RST;
        end else begin
            lv_stat_reg     <= lv_stat_next;
            lv_ie_reg       <= lv_ie_next;
            lv_flag_reg     <= lv_flag_next;
            low_voltage_irq <= lv_flag_next & lv_ie_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog event status, mask and summary interrupt
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_ev_reg   <= `WDSM_EV_RST;
            wd_mask_reg <= `WDSM_EV_RST;
            irq         <= `WDSM_BIT_RST;
        end else begin
            wd_ev_reg   <= wd_ev_next;
            wd_mask_reg <= wd_mask_next;
            irq         <= |(wd_ev_next & wd_mask_next);
        end
    end

endmodule // wdsm_top

`default_nettype wire

// >>> wdsm_assertions.sv
// Purpose: Concurrent checks on the ports of the watchdog/monitor block
// Assumes: One access cycle per APB transfer, sensors quiet during reset
// Notes:   Bound to wdsm_top at the foot of this file
`include "wdsm_map.vh"
`default_nettype none

module wdsm_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  wd_rate_select,
    input wire logic        window_service_mode,
    input wire logic        temp_above_in,
    input wire logic        supply_low_in,
    input wire logic        full_power_state,
    input wire logic        temp_sense_enable,
    input wire logic        monitor_voltage_select,
    input wire logic        temp_irq,
    input wire logic        low_voltage_irq,
    input wire logic        wd_value_rst_req,
    input wire logic        wd_window_rst_req,
    input wire logic        wd_timeout_rst_req
);
    logic [2:0] t_hist;
    logic [2:0] l_hist;
    wire logic  acc    = psel & penable & pready;
    wire logic  rd_ok  = acc & ~pwrite & ~pslverr;
    wire logic  svc_a  = paddr == {`WDSM_IDX_SERVICE, 2'h0};
    wire logic  svc_wr = acc & pwrite & svc_a;
    wire logic  svc_on = svc_wr & (wd_rate_select != `WDSM_RATE_OFF);
    wire logic  good   = (pwdata[7:0] == `WDSM_SVC_ARM) | (pwdata[7:0] == `WDSM_SVC_FIRE);
    wire logic  rd_t   = rd_ok & (paddr == {`WDSM_IDX_TEMP, 2'h0});
    wire logic  rd_l   = rd_ok & (paddr == {`WDSM_IDX_LVOLT, 2'h0});
    wire logic  t_ok   = (&t_hist) | ~(|t_hist);
    wire logic  l_ok   = (&l_hist) | ~(|l_hist);
    wire logic [2:0] rq = {wd_value_rst_req, wd_window_rst_req, wd_timeout_rst_req};

    ////////////////////////////////////////////////////////////////////////////////
    // Recent sensor history
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_hist <= 3'h0;
            l_hist <= 3'h0;
        end else begin
            t_hist <= {t_hist[1:0], temp_above_in & full_power_state};
            l_hist <= {l_hist[1:0], supply_low_in & full_power_state};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_rate_off_quiet: assert property (
        svc_wr && wd_rate_select == `WDSM_RATE_OFF |=> !wd_value_rst_req && !wd_window_rst_req)
        else $error("reset request with watchdog off");
    chk_bad_value_rst: assert property (
        svc_on && !window_service_mode && !good |=> wd_value_rst_req)
        else $error("bad value not reset");
    chk_good_value_quiet: assert property (
        svc_on && !window_service_mode && good |=> !wd_value_rst_req && !wd_window_rst_req)
        else $error("legal value caused reset");
    chk_window_cause: assert property (
        wd_window_rst_req |-> $past(svc_on && window_service_mode))
        else $error("window reset without cause");
    chk_service_reads_zero: assert property (
        acc && !pwrite && svc_a |-> prdata == `WDSM_RDATA_ZERO)
        else $error("service register read not zero");
    chk_ctl_bits_out: assert property (
        rd_t |-> prdata[`WDSM_B_TEN] == temp_sense_enable
              && prdata[`WDSM_B_MONITOR_VOLTAGE_SELECT] == monitor_voltage_select)
        else $error("control outputs differ");
    chk_temp_status: assert property (
        rd_t && t_ok |-> prdata[`WDSM_B_STAT] == t_hist[0])
        else $error("temperature status bit wrong");
    chk_lv_status: assert property (
        rd_l && l_ok |-> prdata[`WDSM_B_STAT] == l_hist[0])
        else $error("low voltage status bit wrong");
    chk_temp_irq: assert property (
        rd_t && t_ok |-> temp_irq == (prdata[`WDSM_B_FLAG] & prdata[`WDSM_B_IE]))
        else $error("temp irq not flag and enable");
    chk_lv_irq: assert property (
        rd_l && l_ok |-> low_voltage_irq == (prdata[`WDSM_B_FLAG] & prdata[`WDSM_B_IE]))
        else $error("lv irq not flag and enable");
    chk_timeout_enabled: assert property (
        wd_timeout_rst_req |-> $past(wd_rate_select) != `WDSM_RATE_OFF)
        else $error("timeout request while watchdog off");
    chk_pulse_single: assert property (
        !(|(rq & $past(rq))))
        else $error("reset request longer than one cycle");

    cov_window_write: cover property (svc_on && window_service_mode);
    cov_timeout: cover property (wd_timeout_rst_req);
    cov_temp_irq_read: cover property (rd_t && temp_irq);
endmodule // wdsm_assertions

bind wdsm_top wdsm_assertions u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .wd_rate_select, .window_service_mode, .temp_above_in, .supply_low_in,
    .full_power_state, .temp_sense_enable, .monitor_voltage_select, .temp_irq,
    .low_voltage_irq, .wd_value_rst_req, .wd_window_rst_req, .wd_timeout_rst_req);
`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for the watchdog/monitor block
// Assumes: One access cycle per APB transfer, byte address is four times the index
// Notes:   Rate code 1 shortened to 16 ticks
`include "wdsm_map.vh"
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, special_mode, wd_tick;
    logic        window_service_mode, temp_above_in, supply_low_in, full_power_state;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  wd_rate_select;
    logic [9:0]  a;
    logic        pready, pslverr, temp_sense_enable, monitor_voltage_select, err;
    logic        temp_irq, low_voltage_irq, v_rq, w_rq, t_rq, irq;
    int          fail_count, n_tests, cyc, n_val, n_win, n_to;

    wdsm_top #(.EXP_1(5'h4)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .special_mode, .wd_tick, .wd_rate_select, .window_service_mode,
        .temp_above_in, .supply_low_in, .full_power_state, .temp_sense_enable,
        .monitor_voltage_select, .temp_irq, .low_voltage_irq, .wd_value_rst_req(v_rq),
        .wd_window_rst_req(w_rq), .wd_timeout_rst_req(t_rq), .irq);

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, reset request counters, timeout
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (presetn && v_rq !== 1'b0) n_val++;
        if (presetn && w_rq !== 1'b0) n_win++;
        if (presetn && t_rq !== 1'b0) n_to++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task tally_and_finish;
        if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // APB master tasks
    task xfer(input logic w, input logic [9:0] idx, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task rchk(input string n, input logic [9:0] idx, input logic [7:0] e);
        xfer(1'b0, idx, 8'h00);
        `CHK(n, e, rd)
    endtask

    task svc(input logic [7:0] v);
        xfer(1'b1, `WDSM_IDX_SERVICE, v);
    endtask

    task idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task ticks(input int n);
        wd_tick <= 1'b1;
        repeat (n) @(posedge pclk);
        wd_tick <= 1'b0;
    endtask

    // Flag set, clear, reduced power, irq off
    task mon(input logic [9:0] idx, input logic [7:0] ctl, input logic s);
        xfer(1'b1, idx, ctl);
        if (s) temp_above_in <= 1'b1;
        else supply_low_in <= 1'b1;
        idle(3);
        rchk("mon_set", idx, ctl | 8'h07);
        `CHK("mon_irq_on", 1'b1, (s ? temp_irq : low_voltage_irq))
        xfer(1'b1, idx, ctl | 8'h01);
        rchk("mon_clr", idx, ctl | 8'h06);
        `CHK("mon_irq_off", 1'b0, (s ? temp_irq : low_voltage_irq))
        full_power_state <= 1'b0;
        idle(3);
        rchk("mon_rpm", idx, ctl | 8'h03);
        xfer(1'b1, idx, ctl ^ 8'h02);
        `CHK("mon_irq_dis", 1'b0, (s ? temp_irq : low_voltage_irq))
        full_power_state <= 1'b1;
        temp_above_in <= 1'b0;
        supply_low_in <= 1'b0;
        idle(3);
        xfer(1'b1, idx, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {psel, penable, pwrite, special_mode, wd_tick, window_service_mode} = 6'h00;
        {temp_above_in, supply_low_in, presetn} = 3'h0;
        full_power_state = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        wd_rate_select = 3'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk("temp_rst", `WDSM_IDX_TEMP, 8'h00);
        rchk("lv_rst", `WDSM_IDX_LVOLT, 8'h00);
        for (int i = 0; i < 2; i++) begin
            a = i ? `WDSM_IDX_TEST1 : `WDSM_IDX_TEST0;
            special_mode <= 1'b0;
            xfer(1'b1, a, 8'ha5);
            rchk("test_norm", a, 8'h00);
            special_mode <= 1'b1;
            xfer(1'b1, a, 8'h5a);
            rchk("test_spec", a, 8'h5a);
        end
        xfer(1'b1, `WDSM_IDX_TEMP, 8'h2e);
        rchk("temp_ctl", `WDSM_IDX_TEMP, 8'h2a);
        `CHK("sense_en", 1'b1, temp_sense_enable)
        `CHK("volt_sel", 1'b1, monitor_voltage_select)
        mon(`WDSM_IDX_TEMP, 8'h2a, 1'b1);
        `CHK("sense_off", 1'b0, temp_sense_enable)
        `CHK("volt_off", 1'b0, monitor_voltage_select)
        mon(`WDSM_IDX_LVOLT, 8'h02, 1'b0);
        svc(8'h13);
        idle(2);
        `CHK("off_quiet", 0, n_val + n_win + n_to)
        wd_rate_select <= 3'h1;
        idle(2);
        ticks(20);
        idle(2);
        `CHK("timeout", 1, n_to)
        for (int i = 0; i < 6; i++) begin
            svc(8'h55);
            svc(8'h55);
            svc(8'haa);
            ticks(10);
        end
        `CHK("kept_alive", 1, n_to)
        `CHK("legal_quiet", 0, n_val + n_win)
        svc(8'haa);
        ticks(6);
        idle(2);
        `CHK("unarmed_fire", 2, n_to)
        svc(8'h12);
        idle(2);
        `CHK("bad_value", 1, n_val)
        svc(8'h55);
        rchk("svc_read", `WDSM_IDX_SERVICE, 8'h00);
        rchk("ev_stat", `WDSM_IDX_WD_STAT, 8'h05);
        `CHK("irq_masked", 1'b0, irq)
        xfer(1'b1, `WDSM_IDX_WD_MASK, 8'h01);
        idle(1);
        `CHK("irq_on", 1'b1, irq)
        xfer(1'b1, `WDSM_IDX_WD_STAT, 8'h01);
        idle(1);
        `CHK("irq_clr", 1'b0, irq)
        rchk("ev_left", `WDSM_IDX_WD_STAT, 8'h04);
        xfer(1'b1, `WDSM_IDX_WD_STAT, 8'h07);
        window_service_mode <= 1'b1;
        svc(8'h55);
        idle(2);
        `CHK("win_early", 1, n_win)
        ticks(13);
        svc(8'h55);
        rchk("wd_state", `WDSM_IDX_WD_STATE, 8'h07);
        svc(8'haa);
        idle(2);
        `CHK("win_late", 1, n_win)
        svc(8'h55);
        idle(2);
        `CHK("win_restart", 2, n_win)
        xfer(1'b0, 10'h100, 8'h00);
        `CHK("unmapped", 1'b1, err)
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
